/* File: common/rsp_map.svh */
// Purpose: constants for the three-line serial register port
// Assumes: system clock of 200 MHz
// Notes: command byte field positions and codes
`ifndef RSP_MAP_SVH
`define RSP_MAP_SVH
`define RSP_CMD_DIR_BIT 7
`define RSP_CMD_SUB_HI 6
`define RSP_CMD_SUB_LO 4
`define RSP_CMD_IDX_HI 3
`define RSP_CMD_IDX_LO 0
`define RSP_SUB_VALID 3'h1
`define RSP_DIR_WRITE 1'h0
`define RSP_DIR_READ 1'h1
`define RSP_IDX_LAST 4'hf
`define RSP_IDX_RESET 4'h0
`define RSP_FIFO_DEPTH 8
`endif

/* File: common/rsp_pkg.sv */
// Purpose: types for the three-line serial register port
// Assumes: nothing
// Notes: register bus carries an index and a byte
package rsp_pkg;
    typedef enum logic [1:0] {
        RSP_IDLE = 2'b00,
        RSP_CMD = 2'b01,
        RSP_DATA = 2'b10,
        RSP_IGNORE = 2'b11
    } rsp_state_e;

    typedef struct packed {
        logic [3:0] idx;
        logic [7:0] data;
    } rsp_wr_s;
endpackage

/* File: rtl/rsp_fifo.sv */
// Purpose: small synchronous fifo with valid/ready on both sides
// Assumes: single clock, synchronous active-high reset
// Notes: depth must be a power of two
`timescale 1ns/1ps
`default_nettype none
module rsp_fifo #(
    parameter int WIDTH = 12,
    parameter int DEPTH = 8
) (
    // clock, reset, enable
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    // fill side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    // drain side
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW:0] wp_q;
    logic [AW:0] rp_q;
    wire full = (wp_q[AW] != rp_q[AW]) && (wp_q[AW-1:0] == rp_q[AW-1:0]);
    wire empty = (wp_q == rp_q);
    wire push = in_valid && !full;
    wire pop = out_ready && !empty;
    assign in_ready = !full;
    assign out_valid = !empty;
    assign out_data = mem_q[rp_q[AW-1:0]];

    always_ff @(posedge clk) begin
        if (ce && push) begin
            mem_q[wp_q[AW-1:0]] <= in_data;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            wp_q <= '0;
            rp_q <= '0;
        end else if (ce) begin
            if (push) begin
                wp_q <= wp_q + 1'b1;
            end
            if (pop) begin
                rp_q <= rp_q + 1'b1;
            end
        end
    end
endmodule
`default_nettype wire

/* File: rtl/rsp_port.sv */
// Purpose: three-line serial register-access port of a real-time clock
// Assumes: serial pins are asynchronous and oversampled by clk (200 MHz)
// Notes: written bytes pass an 8-entry fifo toward the register side;
//        reads fetch through a combinational read port reg_rd_idx/reg_rd_data
// How it works
// (RULE_01) Command and data bytes are accepted only while the select line is high.
// (RULE_02) A low select line returns the state machine, bit counter and byte phase to idle.
// (RULE_03) Every unit is an eight-bit byte shifted most significant bit first.
// (RULE_04) The input line is sampled on each rising serial-clock edge.
// (RULE_05) The output line changes only on falling serial-clock edges.
// (RULE_06) A received byte is committed on the falling edge after its eighth rising edge.
// (RULE_07) The first byte after select rises is the command, later bytes are data.
// (RULE_08) The register pointer loads from the command's register index field.
// (RULE_09) Direction bit 0 means the master writes, 1 means the port returns read data.
// (RULE_10) The pointer advances by one after every data byte read or written.
// (RULE_11) The pointer runs 00h to 0Fh and wraps back to zero after the last one.
// (RULE_12) A subaddress other than 001 makes the port ignore the rest of the transfer.
// (RULE_13) The system may tie input and output lines into one bidirectional line.
// (RULE_14) With separate lines the master always drives the input line high or low.
// (RULE_15) The master returns select low between transactions.
// (RULE_16) Command byte: bit 7 direction, bits 6..4 subaddress, bits 3..0 start index.
// (RULE_17) The output is driven only in the read-data phase of a valid read.
`timescale 1ns/1ps
`default_nettype none
`include "rsp_map.svh"
module rsp_port (
    // clock, reset, enable
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    // serial pins
    input wire logic select_pin,
    input wire logic sclk_pin,
    input wire logic serial_in_pin,
    output logic serial_out_pin,
    output logic serial_out_oe,
    // register side: writes
    output logic wr_valid,
    input wire logic wr_ready,
    output rsp_pkg::rsp_wr_s wr_data,
    // register side: reads
    output logic [3:0] reg_rd_idx,
    input wire logic [7:0] reg_rd_data,
    // status
    output logic overflow
);
    // three-stage synchronisers, one per pin; a level counts once stages 2 and 3 agree
    // index 0 is the select line, 1 the serial clock, 2 the serial input
    wire [2:0] pin_raw = {serial_in_pin, sclk_pin, select_pin};
    wire [2:0] pin_agree;
    wire [2:0] pin_now;
    wire [2:0] pin_lvl;

    for (genvar p = 0; p < 3; p++) begin : g_sync
        logic [2:0] sync_q;
        logic level_q;

        always_ff @(posedge clk) begin
            if (rst) begin
                sync_q <= 3'h0;
            end else if (ce) begin
                sync_q <= {sync_q[1:0], pin_raw[p]};
            end
        end

        // the last agreed level is held, so a pin caught mid-change is not seen twice
        always_ff @(posedge clk) begin
            if (rst) begin
                level_q <= 1'b0;
            end else if (ce && pin_agree[p]) begin
                level_q <= sync_q[2];
            end
        end

        assign pin_agree[p] = (sync_q[1] == sync_q[2]);
        assign pin_now[p] = pin_agree[p] ? sync_q[2] : level_q;
        assign pin_lvl[p] = level_q;
    end

    wire sel_q = pin_lvl[0];
    wire sck_q = pin_lvl[1];
    wire sck_agree = pin_agree[1];
    wire sck_now = pin_now[1];

    // edge detection on the filtered serial clock
    wire sck_rise = sck_agree && sck_now && !sck_q;
    wire sck_fall = sck_agree && !sck_now && sck_q;
    // data is settled well before the clock edge, so the filtered level is safe to use
    wire din_now = pin_now[2];

    // serial state
    rsp_pkg::rsp_state_e state_q;
    rsp_pkg::rsp_state_e state_d;
    logic [2:0] bit_cnt_q;
    logic [7:0] shift_q;
    logic byte_done_q;
    logic dir_q;
    logic [3:0] ptr_q;
    logic [7:0] tx_q;
    logic drive_q;
    logic sout_q;
    logic ovf_q;

    wire [7:0] rx_byte = shift_q;
    wire [2:0] cmd_sub = rx_byte[`RSP_CMD_SUB_HI:`RSP_CMD_SUB_LO]; // [RULE_16]
    wire [3:0] cmd_idx = rx_byte[`RSP_CMD_IDX_HI:`RSP_CMD_IDX_LO]; // [RULE_16]
    wire cmd_dir = rx_byte[`RSP_CMD_DIR_BIT]; // [RULE_16]
    wire cmd_ok = (cmd_sub == `RSP_SUB_VALID); // [RULE_12]
    wire commit = byte_done_q && sck_fall; // [RULE_06]
    wire in_data = (state_q == rsp_pkg::RSP_DATA);
    wire is_read = in_data && (dir_q == `RSP_DIR_READ); // [RULE_09]
    wire is_write = in_data && (dir_q == `RSP_DIR_WRITE); // [RULE_09]
    // index wraps explicitly: RSP_IDX_LAST (0Fh) is followed by RSP_IDX_RESET (00h)
    wire [3:0] ptr_next = (ptr_q == `RSP_IDX_LAST) ? `RSP_IDX_RESET : ptr_q + 4'h1; // [RULE_11]
    wire [3:0] cmd_next = (cmd_idx == `RSP_IDX_LAST) ? `RSP_IDX_RESET : cmd_idx + 4'h1;

    // next-state selection
    always_comb begin
        state_d = state_q;
        case (state_q)
            rsp_pkg::RSP_IDLE: begin
                if (sel_q) begin
                    state_d = rsp_pkg::RSP_CMD; // [RULE_07]
                end
            end
            rsp_pkg::RSP_CMD: begin
                if (commit) begin
                    state_d = cmd_ok ? rsp_pkg::RSP_DATA : rsp_pkg::RSP_IGNORE; // [RULE_12]
                end
            end
            rsp_pkg::RSP_DATA: begin
                state_d = rsp_pkg::RSP_DATA;
            end
            rsp_pkg::RSP_IGNORE: begin
                state_d = rsp_pkg::RSP_IGNORE;
            end
            default: begin
                state_d = rsp_pkg::RSP_IDLE;
            end
        endcase
        if (!sel_q) begin
            state_d = rsp_pkg::RSP_IDLE; // [RULE_02]
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            state_q <= rsp_pkg::RSP_IDLE;
        end else if (ce) begin
            state_q <= state_d;
        end
    end

    // bit counter and receive shifter; a dropped select discards a half byte
    // the select clear sits under ce so that a low enable freezes everything
    wire last_bit = (bit_cnt_q == 3'h7);

    always_ff @(posedge clk) begin
        if (rst) begin
            bit_cnt_q <= 3'h0;
        end else if (ce) begin
            if (!sel_q) begin
                bit_cnt_q <= 3'h0; // [RULE_02]
            end else if (sck_rise) begin
                bit_cnt_q <= bit_cnt_q + 3'h1;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            shift_q <= 8'h00;
        end else if (ce) begin
            if (!sel_q) begin
                shift_q <= 8'h00; // [RULE_02]
            end else if (sck_rise) begin
                shift_q <= {shift_q[6:0], din_now}; // [RULE_03] [RULE_04] [RULE_01]
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            byte_done_q <= 1'b0;
        end else if (ce) begin
            if (!sel_q) begin
                byte_done_q <= 1'b0; // [RULE_02]
            end else if (sck_rise) begin
                byte_done_q <= last_bit;
            end else if (commit) begin
                byte_done_q <= 1'b0;
            end
        end
    end

    // command decode, pointer and direction
    wire cmd_commit = commit && (state_q == rsp_pkg::RSP_CMD);
    wire data_commit = commit && in_data;
    // a read has already fetched the first byte, so point past it
    wire [3:0] ptr_load = (cmd_dir == `RSP_DIR_READ) ? cmd_next : cmd_idx; // [RULE_08]

    always_ff @(posedge clk) begin
        if (rst) begin
            dir_q <= `RSP_DIR_WRITE;
        end else if (ce && cmd_commit) begin
            dir_q <= cmd_dir; // [RULE_09]
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            ptr_q <= `RSP_IDX_RESET;
        end else if (ce) begin
            if (cmd_commit) begin
                ptr_q <= ptr_load; // [RULE_08]
            end else if (data_commit) begin
                ptr_q <= ptr_next; // [RULE_10] [RULE_11]
            end
        end
    end

    // read fetch: the register at cmd_idx on the command commit, then at the pointer on each data commit, is latched
    assign reg_rd_idx = (state_q == rsp_pkg::RSP_CMD) ? cmd_idx : ptr_q;

    // transmit shifter: loads on the commit fall, then shifts on each later fall
    wire read_cmd = cmd_commit && cmd_ok && (cmd_dir == `RSP_DIR_READ); // [RULE_12]
    wire tx_load = read_cmd || (commit && is_read); // [RULE_09]
    wire tx_shift = sck_fall && !tx_load && drive_q; // [RULE_05]

    always_ff @(posedge clk) begin
        if (rst) begin
            tx_q <= 8'h00;
        end else if (ce) begin
            if (!sel_q) begin
                tx_q <= 8'h00;
            end else if (tx_load) begin
                tx_q <= {reg_rd_data[6:0], 1'b0}; // [RULE_03]
            end else if (tx_shift) begin
                tx_q <= {tx_q[6:0], 1'b0};
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            sout_q <= 1'b0;
        end else if (ce) begin
            if (!sel_q) begin
                sout_q <= 1'b0;
            end else if (tx_load) begin
                sout_q <= reg_rd_data[7]; // [RULE_05]
            end else if (tx_shift) begin
                sout_q <= tx_q[7]; // [RULE_05]
            end
        end
    end

    // the enable only rises with a valid read, so a tied data line never contends
    always_ff @(posedge clk) begin
        if (rst) begin
            drive_q <= 1'b0;
        end else if (ce) begin
            if (!sel_q) begin
                drive_q <= 1'b0; // [RULE_17] [RULE_02]
            end else if (tx_load) begin
                drive_q <= 1'b1; // [RULE_17] [RULE_09]
            end
        end
    end

    // write path into the fifo; a full fifo drops the byte and flags it
    wire wr_push = ce && commit && is_write; // [RULE_09] [RULE_12]
    rsp_pkg::rsp_wr_s push_word;
    assign push_word.idx = ptr_q;
    assign push_word.data = rx_byte;
    logic fifo_in_ready;
    logic [11:0] fifo_out;

    rsp_fifo #(
        .WIDTH(12),
        .DEPTH(`RSP_FIFO_DEPTH)
    ) rsp_fifo_inst (
        .clk(clk),
        .rst(rst),
        .ce(ce),
        .in_valid(wr_push),
        .in_ready(fifo_in_ready),
        .in_data(push_word),
        .out_valid(wr_valid),
        .out_ready(wr_ready),
        .out_data(fifo_out)
    );
    assign wr_data = fifo_out;

    // the serial master cannot be stalled, so back-pressure shows as a sticky flag
    always_ff @(posedge clk) begin
        if (rst) begin
            ovf_q <= 1'b0;
        end else if (ce && wr_push && !fifo_in_ready) begin
            ovf_q <= 1'b1;
        end
    end

    assign serial_out_pin = sout_q;
    assign serial_out_oe = drive_q && sel_q; // [RULE_17] [RULE_13]
    assign overflow = ovf_q;
endmodule
`default_nettype wire

/* File: verif/rsp_port_checker.sv */
// Purpose: port-level checks for rsp_port
// Assumes: ce held high by the bench
// Notes: pins pass a filter, so outputs lag them by about 4 clk
`timescale 1ns/1ps
`default_nettype none
module rsp_port_checker (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // serial pins
    input wire logic select_pin,
    input wire logic sclk_pin,
    input wire logic serial_out_pin,
    input wire logic serial_out_oe,
    // register side
    input wire logic wr_valid,
    input wire logic wr_ready,
    input wire rsp_pkg::rsp_wr_s wr_data,
    input wire logic overflow
);
    default clocking @(posedge clk);
    endclocking
    default disable iff (rst);
    AST_RESET_QUIET: assert property (disable iff (1'b0) rst |=> !serial_out_oe && !wr_valid)
        else $error("outputs active after reset");
    AST_OE_DROP: assert property (!select_pin [*7] |-> !serial_out_oe)
        else $error("output enabled without select");
    AST_OUT_ON_FALL: assert property ($changed(serial_out_pin) |-> !sclk_pin && $past(!sclk_pin, 2))
        else $error("data out moved outside a falling edge");
    AST_OUT_STEADY: assert property (sclk_pin && $past(sclk_pin, 4) |-> $stable(serial_out_pin))
        else $error("data out moved while clock high");
    AST_OE_RISE: assert property ($rose(serial_out_oe) |-> !sclk_pin && select_pin)
        else $error("output enable rose at a bad moment");
    AST_WR_IN_FRAME: assert property ($rose(wr_valid) |-> select_pin && $past(select_pin, 8))
        else $error("write word outside a frame");
    AST_HOLD_WR: assert property (wr_valid && !wr_ready |=> wr_valid && $stable(wr_data))
        else $error("write word dropped while stalled");
    AST_OVF_STICKY: assert property (overflow |=> overflow)
        else $error("overflow cleared without reset");
    cover property ($rose(serial_out_oe));
    cover property ($rose(overflow));
    cover property (wr_valid && wr_ready);
endmodule
bind rsp_port rsp_port_checker rsp_port_checker_inst (.clk, .rst, .select_pin, .sclk_pin,
    .serial_out_pin, .serial_out_oe, .wr_valid, .wr_ready, .wr_data, .overflow);
`default_nettype wire

/* File: verif/rsp_master.sv */
// Purpose: serial bus master model driving the port
// Assumes: 160 ns serial clock, idling low outside frames
// Notes: data in keeps being driven between frames
`timescale 1ns/1ps
`default_nettype none
module rsp_master (
    // serial pins
    output logic select_pin,
    output logic sclk_pin,
    output logic serial_in_pin,
    input wire logic serial_out_pin
);
    initial begin
        select_pin = 1'b0;
        sclk_pin = 1'b0;
        serial_in_pin = 1'b0;
    end
    task automatic open();
        select_pin = 1'b1;
        #80;
    endtask
    // nbits below 8 cuts the byte short to test an abort
    task automatic put(input logic [7:0] tx, input int nbits, output logic [7:0] rx);
        rx = 8'h00;
        for (int i = 7; i > 7 - nbits; i--) begin
            serial_in_pin = tx[i];
            #80 sclk_pin = 1'b1;
            rx[i] = serial_out_pin;
            #80 sclk_pin = 1'b0;
        end
        serial_in_pin = ~serial_in_pin;
    endtask
    task automatic close();
        #80 select_pin = 1'b0;
        #200;
    endtask
endmodule
`default_nettype wire

/* File: verif/rsp_port_test.sv */
// Purpose: self-checking bench for rsp_port
// Assumes: register side modelled here as 16 bytes
// Notes: overflow test runs last since only reset clears it
`timescale 1ns/1ps
`default_nettype none
module rsp_port_test;
    logic clk, rst, ce, wr_ready, select_pin, sclk_pin, serial_in_pin, serial_out_pin;
    logic serial_out_oe, wr_valid, overflow, oe_seen;
    rsp_pkg::rsp_wr_s wr_data;
    logic [3:0] reg_rd_idx;
    logic [7:0] reg_rd_data, rx;
    logic [7:0] regs [16];
    rsp_pkg::rsp_wr_s got [$];
    int fail_count = 0;
    int samples_checked = 0;
    assign reg_rd_data = regs[reg_rd_idx];
    rsp_port rsp_port_inst (.clk, .rst, .ce, .select_pin, .sclk_pin, .serial_in_pin,
        .serial_out_pin, .serial_out_oe, .wr_valid, .wr_ready, .wr_data, .reg_rd_idx,
        .reg_rd_data, .overflow);
    rsp_master rsp_master_inst (.select_pin, .sclk_pin, .serial_in_pin, .serial_out_pin);
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    always @(posedge clk) begin
        if (wr_valid === 1'b1 && wr_ready === 1'b1)
            got.push_back(wr_data);
        if (serial_out_oe === 1'b1)
            oe_seen = 1'b1;
    end
    task automatic check(input logic [11:0] seen, input logic [11:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            fail_count++;
            $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wrap_up();
        if (fail_count == 0 && samples_checked > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    task automatic frame2(input logic [7:0] cmd, input logic [7:0] dat);
        rsp_master_inst.open();
        rsp_master_inst.put(cmd, 8, rx);
        rsp_master_inst.put(dat, 8, rx);
        rsp_master_inst.close();
    endtask
    task automatic t_write_wrap();
        got = {};
        rsp_master_inst.open();
        rsp_master_inst.put(8'h1e, 8, rx);
        rsp_master_inst.put(8'ha5, 8, rx);
        rsp_master_inst.put(8'h3c, 8, rx);
        rsp_master_inst.put(8'h81, 8, rx);
        rsp_master_inst.close();
        check(12'(got.size()), 12'h003);
        check(got[0], 12'hea5);
        check(got[1], 12'hf3c);
        check(got[2], 12'h081);
    endtask
    task automatic t_read_wrap();
        got = {};
        oe_seen = 1'b0;
        rsp_master_inst.open();
        rsp_master_inst.put(8'h9f, 8, rx);
        rsp_master_inst.put(8'h00, 8, rx);
        check({4'h0, rx}, 12'h0f0);
        rsp_master_inst.put(8'h00, 8, rx);
        check({4'h0, rx}, 12'h00f);
        rsp_master_inst.close();
        check({11'h000, oe_seen}, 12'h001);
        check(12'(got.size()), 12'h000);
    endtask
    task automatic t_bad_sub();
        got = {};
        oe_seen = 1'b0;
        for (int s = 0; s < 16; s++) begin
            if (s[2:0] != 3'h1)
                frame2({s[3], s[2:0], 4'h2}, 8'h55);
        end
        check(12'(got.size()), 12'h000);
        check({11'h000, oe_seen}, 12'h000);
    endtask
    task automatic t_abort();
        got = {};
        rsp_master_inst.open();
        rsp_master_inst.put(8'h13, 8, rx);
        rsp_master_inst.put(8'hff, 5, rx);
        rsp_master_inst.close();
        frame2(8'h17, 8'h42);
        check(12'(got.size()), 12'h001);
        check(got[0], 12'h742);
    endtask
    task automatic t_full();
        got = {};
        @(negedge clk) wr_ready = 1'b0;
        rsp_master_inst.open();
        rsp_master_inst.put(8'h10, 8, rx);
        for (int k = 0; k < 9; k++)
            rsp_master_inst.put(8'(k), 8, rx);
        rsp_master_inst.close();
        check({11'h000, overflow}, 12'h001);
        @(negedge clk) wr_ready = 1'b1;
        for (int n = 0; n < 40 && wr_valid !== 1'b0; n++)
            @(negedge clk);
        check(12'(got.size()), 12'h008);
        for (int k = 0; k < 8; k++)
            check(got[k], {k[3:0], 8'(k)});
    endtask
    initial begin
        rst = 1'b1;
        ce = 1'b1;
        wr_ready = 1'b1;
        oe_seen = 1'b0;
        for (int i = 0; i < 16; i++)
            regs[i] = {i[3:0], ~i[3:0]};
        repeat (5) @(negedge clk);
        rst = 1'b0;
        repeat (4) @(negedge clk);
        t_write_wrap();
        t_read_wrap();
        t_bad_sub();
        t_abort();
        t_full();
        wrap_up();
    end
    initial begin
        #200000;
        fail_count++;
        wrap_up();
    end
endmodule
`default_nettype wire
